// ===== hdl/sleep_policy_pkg.sv
package sleep_policy_pkg;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  typedef logic [2:0] mode_sel_t;
  typedef logic [2:0] reg_sel_t;

  localparam mode_sel_t SLEEP_IDLE      = 3'h0;
  localparam mode_sel_t SLEEP_STANDBY   = 3'h1;
  localparam mode_sel_t SLEEP_POWERDOWN = 3'h2;

  localparam reg_sel_t  REG_AUTO        = 3'h0;
  localparam reg_sel_t  REG_FULL        = 3'h1;

  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int        CLK_HZ          = 20_000_000;
  localparam int        STBY_GROUP_N    = 7;
  localparam int        LUT_N           = 4;
  localparam int        PIN_N           = 8;
  localparam int        WAKE_CNT_W      = 3;
  localparam logic [2:0] WAKE_CLOCKS    = 3'h6;
  localparam logic [2:0] WAKE_CNT_ZERO  = 3'h0;
  localparam logic [2:0] WAKE_CNT_STEP  = 3'h1;

  // asynchronous lookup path: no filter, no edge detector
  localparam logic [1:0] LUT_FILTER_OFF = 2'h0;
  localparam logic      LUT_EDGE_OFF    = 1'h0;

  typedef logic [LUT_N-1:0][1:0] lut_filter_t;

  typedef enum {ST_ACTIVE, ST_ASLEEP, ST_WAKING} policy_state_t;

endpackage

// ===== hdl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // pin side and synchronised side
  input  wire logic [W-1:0] pinIn,
  output var  logic [W-1:0] pinSync
);

  logic [W-1:0] meta;

  // two stages; the first stage feeds only the second
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta    <= '0;
      pinSync <= '0;
    end
    else
    begin
      meta    <= pinIn;
      pinSync <= meta;
    end
  end

endmodule
`default_nettype wire

// ===== hdl/wake_source_filter.sv
`timescale 1ns/1ps
`default_nettype none
module wake_source_filter (
  // sleep context
  input  wire logic                              asleep,
  input  wire sleep_policy_pkg::mode_sel_t       mode,
  input  wire logic                              hotLeak,
  input  wire logic                              periphClkStopped,
  input  wire logic                              rtcRunStandby,
  // pin sources, already synchronised
  input  wire logic [sleep_policy_pkg::PIN_N-1:0] pinAsyncIrq,
  input  wire logic [sleep_policy_pkg::PIN_N-1:0] pinSyncIrq,
  // peripheral sources
  input  wire logic                              levelMonIrq,
  input  wire logic                              rtcIrq,
  input  wire logic                              tickIrq,
  input  wire logic                              addrMatchIrq,
  input  wire logic [sleep_policy_pkg::LUT_N-1:0] lutIrq,
  input  wire sleep_policy_pkg::lut_filter_t     lutFilterSelect,
  input  wire logic [sleep_policy_pkg::LUT_N-1:0] lutEdgeDetect,
  input  wire logic                              sofIrq,
  input  wire logic [sleep_policy_pkg::STBY_GROUP_N-1:0] groupIrq,
  input  wire logic                              otherIrq,
  // result
  output var  logic                              wakeHit
);
  import sleep_policy_pkg::*;

  logic [LUT_N-1:0] lutWake;
  logic             pinWake;
  logic             anyIrq;

  // outside idle, a lookup table may only wake through a clockless path
  genvar g;
  generate
    for (g = 0; g < LUT_N; g++)
    begin : g_lut
      assign lutWake[g] = lutIrq[g] && (lutFilterSelect[g] == LUT_FILTER_OFF)
                          && (lutEdgeDetect[g] == LUT_EDGE_OFF);
    end
  endgenerate

  // synchronous pin sensing is dead once the peripheral clock stops
  assign pinWake = (|pinAsyncIrq) || ((|pinSyncIrq) && !periphClkStopped);

  assign anyIrq = (|pinAsyncIrq) || (|pinSyncIrq) || levelMonIrq || rtcIrq || tickIrq
                  || addrMatchIrq || (|lutIrq) || sofIrq || (|groupIrq) || otherIrq;

  // per-mode wake source selection
  always_comb
  begin
    wakeHit = 1'h0;
    if (asleep)
    begin
      unique case (mode)
        SLEEP_IDLE:      wakeHit = anyIrq;
        SLEEP_STANDBY:   wakeHit = pinWake || levelMonIrq || (rtcIrq && rtcRunStandby)
                                   || tickIrq || addrMatchIrq || (|lutWake) || sofIrq
                                   || (|groupIrq);
        SLEEP_POWERDOWN: wakeHit = pinWake || levelMonIrq || tickIrq
                                   || (!hotLeak && (addrMatchIrq || (|lutWake)));
        default:         wakeHit = 1'h0;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== hdl/sleep_mode_power_policy.sv
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_power_policy (
  // clock and reset
  input  wire logic                                      clk,
  input  wire logic                                      rstn,
  // cpu side
  input  wire logic                                      sleepRequest,
  input  wire logic                                      sleepEnableBit,
  input  wire sleep_policy_pkg::mode_sel_t               sleepModeSelect,
  input  wire sleep_policy_pkg::reg_sel_t                regulatorPowerSelect,
  input  wire logic                                      hotLeakageReduceEnable,
  // oscillator state
  input  wire logic                                      lowSpeedOnly,
  input  wire logic                                      mainOnLowSpeed,
  input  wire logic                                      brownoutSampledMode,
  input  wire logic                                      tickEnable,
  // run-in-standby settings
  input  wire logic                                      mainRunStandby,
  input  wire logic                                      customClkRunStandby,
  input  wire logic                                      rtcRunStandby,
  input  wire logic [sleep_policy_pkg::STBY_GROUP_N-1:0] groupRunStandby,
  // wake sources from pins
  input  wire logic [sleep_policy_pkg::PIN_N-1:0]        pinAsyncIrq,
  input  wire logic [sleep_policy_pkg::PIN_N-1:0]        pinSyncIrq,
  // wake sources from peripherals
  input  wire logic                                      levelMonIrq,
  input  wire logic                                      rtcIrq,
  input  wire logic                                      tickIrq,
  input  wire logic                                      addrMatchIrq,
  input  wire logic [sleep_policy_pkg::LUT_N-1:0]        lutIrq,
  input  wire sleep_policy_pkg::lut_filter_t             lutFilterSelect,
  input  wire logic [sleep_policy_pkg::LUT_N-1:0]        lutEdgeDetect,
  input  wire logic                                      sofIrq,
  input  wire logic [sleep_policy_pkg::STBY_GROUP_N-1:0] groupIrq,
  input  wire logic                                      otherIrq,
  // regulator and cpu control
  output var  logic                                      cpuHalt,
  output var  logic                                      regulatorLowPower,
  output var  logic                                      leakageReduce,
  // clock source gates
  output var  logic                                      mainClkRun,
  output var  logic                                      customClkRun,
  output var  logic                                      timerDClkRun,
  output var  logic                                      rtcClkRun,
  output var  logic                                      wdtOscRun,
  output var  logic                                      brownoutOscRun,
  // peripheral gates
  output var  logic [sleep_policy_pkg::STBY_GROUP_N-1:0] periphRun,
  output var  logic                                      otherPeriphRun,
  output var  logic                                      rtcRun,
  output var  logic                                      tickRun,
  output var  logic                                      alwaysOnRun,
  // status
  output var  logic                                      sleeping,
  output var  logic                                      wakeEvent
);
  import sleep_policy_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  policy_state_t          state;
  mode_sel_t              sleepMode;
  logic [WAKE_CNT_W-1:0]  wakeCnt;
  logic [PIN_N-1:0]       pinAsyncSync;
  logic [PIN_N-1:0]       pinSyncSync;
  logic                   wakeHit;
  logic                   asleep;
  logic                   inIdle;
  logic                   inStby;
  logic                   inPd;
  logic                   regAuto;
  logic                   modeLegal;
  logic                   periphClkStopped;

  logic                   next_cpuHalt;
  logic                   next_regulatorLowPower;
  logic                   next_leakageReduce;
  logic                   next_mainClkRun;
  logic                   next_customClkRun;
  logic                   next_timerDClkRun;
  logic                   next_rtcClkRun;
  logic                   next_brownoutOscRun;
  logic [STBY_GROUP_N-1:0] next_periphRun;
  logic                   next_otherPeriphRun;
  logic                   next_rtcRun;
  logic                   next_tickRun;

  // ----------------------------------------------------------------
  // pin synchronisers and wake selection
  // ----------------------------------------------------------------
  pin_sync #(.W(PIN_N)) u_sync_async (
    .clk     (clk),
    .rstn    (rstn),
    .pinIn   (pinAsyncIrq),
    .pinSync (pinAsyncSync)
  );

  pin_sync #(.W(PIN_N)) u_sync_sync (
    .clk     (clk),
    .rstn    (rstn),
    .pinIn   (pinSyncIrq),
    .pinSync (pinSyncSync)
  );

  wake_source_filter u_wake (
    .asleep           (asleep),
    .mode             (sleepMode),
    .hotLeak          (hotLeakageReduceEnable),
    .periphClkStopped (periphClkStopped),
    .rtcRunStandby    (rtcRunStandby),
    .pinAsyncIrq      (pinAsyncSync),
    .pinSyncIrq       (pinSyncSync),
    .levelMonIrq      (levelMonIrq),
    .rtcIrq           (rtcIrq),
    .tickIrq          (tickIrq),
    .addrMatchIrq     (addrMatchIrq),
    .lutIrq           (lutIrq),
    .lutFilterSelect  (lutFilterSelect),
    .lutEdgeDetect    (lutEdgeDetect),
    .sofIrq           (sofIrq),
    .groupIrq         (groupIrq),
    .otherIrq         (otherIrq),
    .wakeHit          (wakeHit)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // reserved sleep codes are refused; reserved regulator codes fall back to full drive
  assign modeLegal = (sleepModeSelect == SLEEP_IDLE) || (sleepModeSelect == SLEEP_STANDBY)
                     || (sleepModeSelect == SLEEP_POWERDOWN);
  assign regAuto   = (regulatorPowerSelect == REG_AUTO);
  assign asleep    = (state == ST_ASLEEP);
  assign inIdle    = asleep && (sleepMode == SLEEP_IDLE);
  assign inStby    = asleep && (sleepMode == SLEEP_STANDBY);
  assign inPd      = asleep && (sleepMode == SLEEP_POWERDOWN);
  assign periphClkStopped = inPd || (inStby && !mainRunStandby);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // mode is latched at entry so later writes cannot change a sleep in progress
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state     <= ST_ACTIVE;
      sleepMode <= SLEEP_IDLE;
    end
    else
    begin
      unique case (state)
        ST_ACTIVE:
          if (sleepRequest && sleepEnableBit && modeLegal)
          begin
            state     <= ST_ASLEEP;
            sleepMode <= sleepModeSelect;
          end
        ST_ASLEEP:
          if (wakeHit)
            state <= ST_WAKING;
        ST_WAKING:
          if (wakeCnt == WAKE_CLOCKS - WAKE_CNT_STEP)
            state <= ST_ACTIVE;
      endcase
    end
  end

  // wake delay counter, gives clocks and regulator time to settle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wakeCnt <= WAKE_CNT_ZERO;
    else if (state == ST_WAKING)
      wakeCnt <= wakeCnt + WAKE_CNT_STEP;
    else
      wakeCnt <= WAKE_CNT_ZERO;
  end

  // one-cycle wake marker and sleep status
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wakeEvent <= 1'h0;
      sleeping  <= 1'h0;
    end
    else
    begin
      wakeEvent <= asleep && wakeHit;
      sleeping  <= asleep;
    end
  end

  // ----------------------------------------------------------------
  // policy
  // ----------------------------------------------------------------
  // waking shows the active clock and peripheral settings but keeps cpuHalt set, so the cpu never runs early
  always_comb
  begin
    next_cpuHalt          = (state != ST_ACTIVE);
    next_regulatorLowPower = regAuto && (mainOnLowSpeed || inStby || inPd
                                         || (asleep && lowSpeedOnly));
    next_leakageReduce    = inPd && regAuto && hotLeakageReduceEnable;
    next_mainClkRun       = !inPd && !(inStby && !mainRunStandby);
    next_customClkRun     = !inPd && !(inStby && !customClkRunStandby);
    next_timerDClkRun     = !inStby && !inPd;
    next_rtcClkRun        = inStby ? (rtcRunStandby || tickEnable)
                                   : (inPd ? tickEnable : 1'h1);
    next_brownoutOscRun   = asleep ? brownoutSampledMode : 1'h1;
    next_periphRun        = inPd ? '0 : (inStby ? groupRunStandby : '1);
    next_otherPeriphRun   = !inStby && !inPd;
    next_rtcRun           = !inPd && !(inStby && !rtcRunStandby);
    next_tickRun          = 1'h1;
  end

  // every gate is registered so outputs stay glitch free
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cpuHalt           <= 1'h0;
      regulatorLowPower <= 1'h0;
      leakageReduce     <= 1'h0;
      mainClkRun        <= 1'h1;
      customClkRun      <= 1'h1;
      timerDClkRun      <= 1'h1;
      rtcClkRun         <= 1'h1;
      wdtOscRun         <= 1'h1;
      brownoutOscRun    <= 1'h1;
      periphRun         <= '1;
      otherPeriphRun    <= 1'h1;
      rtcRun            <= 1'h1;
      tickRun           <= 1'h1;
      alwaysOnRun       <= 1'h1;
    end
    else
    begin
      cpuHalt           <= next_cpuHalt;
      regulatorLowPower <= next_regulatorLowPower;
      leakageReduce     <= next_leakageReduce;
      mainClkRun        <= next_mainClkRun;
      customClkRun      <= next_customClkRun;
      timerDClkRun      <= next_timerDClkRun;
      rtcClkRun         <= next_rtcClkRun;
      wdtOscRun         <= 1'h1;
      brownoutOscRun    <= next_brownoutOscRun;
      periphRun         <= next_periphRun;
      otherPeriphRun    <= next_otherPeriphRun;
      rtcRun            <= next_rtcRun;
      tickRun           <= next_tickRun;
      alwaysOnRun       <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_full_max_drive: assert property (
    !regAuto |=> !regulatorLowPower)
    else $error("full regulator setting left maximum drive");
  a_lowspeed_low_power: assert property (
    regAuto && asleep && lowSpeedOnly |=> regulatorLowPower)
    else $error("low-speed sleep kept regulator at full drive");
  a_deep_low_power: assert property (
    regAuto && (inStby || inPd) |=> regulatorLowPower)
    else $error("deep sleep in auto kept regulator at full drive");
  a_idle_all_run: assert property (
    inIdle |=> cpuHalt && otherPeriphRun && (&periphRun) && mainClkRun)
    else $error("idle stopped a peripheral or kept cpu running");
  a_standby_group: assert property (
    inStby |=> (periphRun == $past(groupRunStandby)) && !otherPeriphRun)
    else $error("standby gating ignores run-in-standby");
  a_pd_clocks_off: assert property (
    inPd |=> !mainClkRun && !customClkRun && !timerDClkRun && (periphRun == '0))
    else $error("power-down left a fast clock running");
  a_hot_leak: assert property (
    inPd && regAuto && hotLeakageReduceEnable |=> leakageReduce)
    else $error("hot leakage reduction not applied");
  a_leak_only_pd: assert property (
    !inPd |=> !leakageReduce)
    else $error("leakage reduction outside power-down");
  a_always_on: assert property (
    ##1 alwaysOnRun && wdtOscRun)
    else $error("always-on function was stopped");
  a_brownout_osc: assert property (
    asleep |=> brownoutOscRun == $past(brownoutSampledMode))
    else $error("brown-out oscillator wrong while asleep");
  a_reserved_refused: assert property (
    (state == ST_ACTIVE) && sleepRequest && !modeLegal |=> state == ST_ACTIVE)
    else $error("reserved sleep code entered sleep");
  a_wake_restore: assert property (
    wakeEvent |-> ##1 (mainClkRun && !regulatorLowPower || regAuto && mainOnLowSpeed)
                  ##5 cpuHalt ##1 !cpuHalt)
    else $error("wake sequence timing wrong");

  c_enter_idle:  cover property ((state == ST_ACTIVE) ##1 inIdle);
  c_enter_stby:  cover property ((state == ST_ACTIVE) ##1 inStby);
  c_wake_pd:     cover property (inPd && wakeHit ##1 wakeEvent);
  c_hot_pd:      cover property (inPd && hotLeakageReduceEnable && regAuto);

endmodule
`default_nettype wire

// ===== verification/periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module periph_model (
  // setting seen by software
  input  wire logic                                     hotLeak,
  // raise command from the bench
  input  wire logic [9:0]                               raise,
  // interrupt levels
  output var  logic [sleep_policy_pkg::PIN_N-1:0]        pinAsyncIrq,
  output var  logic [sleep_policy_pkg::PIN_N-1:0]        pinSyncIrq,
  output var  logic                                     levelMonIrq,
  output var  logic                                     rtcIrq,
  output var  logic                                     tickIrq,
  output var  logic                                     addrMatchIrq,
  output var  logic [sleep_policy_pkg::LUT_N-1:0]        lutIrq,
  output var  logic                                     sofIrq,
  output var  logic [sleep_policy_pkg::STBY_GROUP_N-1:0] groupIrq,
  output var  logic                                     otherIrq
);
  import sleep_policy_pkg::*;
  // ----------------------------------------------
  // interrupt sources
  // ----------------------------------------------
  // levels stay up until the bench drops them
  assign levelMonIrq = raise[0];
  assign rtcIrq      = raise[1];
  assign tickIrq     = raise[2];
  assign sofIrq      = raise[5];
  assign otherIrq    = raise[7];
  assign groupIrq    = {6'h00, raise[6]};
  assign pinAsyncIrq = {7'h00, raise[8]};
  assign pinSyncIrq  = {7'h00, raise[9]};
  // software turns these wakes off before hot leakage mode, else behaviour is undefined
  assign addrMatchIrq = raise[3] & ~hotLeak;
  assign lutIrq      = {3'h0, raise[4] & ~hotLeak};
endmodule
`default_nettype wire

// ===== verification/test_sleep_mode_power_policy.sv
`timescale 1ns/1ps
`default_nettype none
module test_sleep_mode_power_policy;
  import sleep_policy_pkg::*;
  // ----------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------
  logic clk = 1'h0, rstn = 1'h0, sleepRequest = 1'h0, sleepEnableBit = 1'h1;
  logic hotLeakageReduceEnable = 1'h0, lowSpeedOnly = 1'h0, mainOnLowSpeed = 1'h0;
  logic brownoutSampledMode = 1'h0, tickEnable = 1'h0, mainRunStandby = 1'h0;
  logic customClkRunStandby = 1'h0, rtcRunStandby = 1'h0;
  logic [6:0] groupRunStandby = 7'h00;
  logic [3:0] lutEdgeDetect = 4'h0;
  logic [9:0] raise = 10'h000;
  mode_sel_t sleepModeSelect = SLEEP_IDLE;
  reg_sel_t regulatorPowerSelect = REG_AUTO;
  lut_filter_t lutFilterSelect = 8'h00;
  logic [7:0] pinAsyncIrq, pinSyncIrq;
  logic [3:0] lutIrq;
  logic [6:0] groupIrq, periphRun;
  logic levelMonIrq, rtcIrq, tickIrq, addrMatchIrq, sofIrq, otherIrq, cpuHalt, regulatorLowPower;
  logic leakageReduce, mainClkRun, customClkRun, timerDClkRun, rtcClkRun, wdtOscRun;
  logic brownoutOscRun, otherPeriphRun, rtcRun, tickRun, alwaysOnRun, sleeping, wakeEvent;
  int nFail = 0, checksDone = 0;

  sleep_mode_power_policy sleep_mode_power_policy_i (
    .clk(clk), .rstn(rstn), .sleepRequest(sleepRequest), .sleepEnableBit(sleepEnableBit),
    .sleepModeSelect(sleepModeSelect), .regulatorPowerSelect(regulatorPowerSelect),
    .hotLeakageReduceEnable(hotLeakageReduceEnable), .lowSpeedOnly(lowSpeedOnly),
    .mainOnLowSpeed(mainOnLowSpeed), .brownoutSampledMode(brownoutSampledMode),
    .tickEnable(tickEnable), .mainRunStandby(mainRunStandby),
    .customClkRunStandby(customClkRunStandby),
    .rtcRunStandby(rtcRunStandby), .groupRunStandby(groupRunStandby),
    .pinAsyncIrq(pinAsyncIrq), .pinSyncIrq(pinSyncIrq), .levelMonIrq(levelMonIrq),
    .rtcIrq(rtcIrq), .tickIrq(tickIrq), .addrMatchIrq(addrMatchIrq), .lutIrq(lutIrq),
    .lutFilterSelect(lutFilterSelect), .lutEdgeDetect(lutEdgeDetect), .sofIrq(sofIrq),
    .groupIrq(groupIrq), .otherIrq(otherIrq), .cpuHalt(cpuHalt),
    .regulatorLowPower(regulatorLowPower), .leakageReduce(leakageReduce),
    .mainClkRun(mainClkRun), .customClkRun(customClkRun), .timerDClkRun(timerDClkRun),
    .rtcClkRun(rtcClkRun), .wdtOscRun(wdtOscRun), .brownoutOscRun(brownoutOscRun),
    .periphRun(periphRun), .otherPeriphRun(otherPeriphRun), .rtcRun(rtcRun),
    .tickRun(tickRun), .alwaysOnRun(alwaysOnRun), .sleeping(sleeping), .wakeEvent(wakeEvent));

  periph_model periph_model_i (
    .hotLeak(hotLeakageReduceEnable), .raise(raise), .pinAsyncIrq(pinAsyncIrq),
    .pinSyncIrq(pinSyncIrq), .levelMonIrq(levelMonIrq), .rtcIrq(rtcIrq), .tickIrq(tickIrq),
    .addrMatchIrq(addrMatchIrq), .lutIrq(lutIrq), .sofIrq(sofIrq), .groupIrq(groupIrq),
    .otherIrq(otherIrq));

  // 20 MHz clock
  always #25 clk = ~clk;

  // ----------------------------------------------
  // shared tasks
  // ----------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      nFail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // inputs always move 2 ns after the edge so outputs are settled when read
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic enter(input mode_sel_t mode);
    sleepModeSelect = mode;
    sleepRequest = 1'h1;
    step(1);
    sleepRequest = 1'h0;
    step(2);
  endtask

  // source held for six cycles, long enough to pass the pin synchroniser
  task automatic hold(input logic [9:0] src);
    raise = src;
    step(6);
    raise = 10'h000;
  endtask

  task automatic wake(input logic [9:0] src);
    int i;
    raise = src;
    i = 0;
    while (wakeEvent !== 1'h1 && i < 8)
    begin
      step(1);
      i++;
    end
    check("wakeEvent", wakeEvent, 8'h01);
    step(1);
    raise = 10'h000;
    check("sleeping", sleeping, 8'h00);
    check("mainClkRun", mainClkRun, 8'h01);
    step(5);
    check("cpuHalt c6", cpuHalt, 8'h01);
    step(1);
    check("cpuHalt c7", cpuHalt, 8'h00);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------
  // scenarios
  // ----------------------------------------------
  task automatic test_refuse();
    enter(3'h3);
    check("mode 3", sleeping, 8'h00);
    enter(3'h7);
    check("mode 7", sleeping, 8'h00);
    mainOnLowSpeed = 1'h1;
    step(2);
    check("slow main reg", regulatorLowPower, 8'h01);
    regulatorPowerSelect = 3'h5;
    step(2);
    check("reserved reg", regulatorLowPower, 8'h00);
    regulatorPowerSelect = REG_AUTO;
    mainOnLowSpeed = 1'h0;
    step(2);
    $display("test_refuse done");
  endtask

  task automatic test_idle();
    enter(SLEEP_IDLE);
    check("idle halt", cpuHalt, 8'h01);
    check("idle others", otherPeriphRun, 8'h01);
    check("idle timer d", timerDClkRun, 8'h01);
    check("idle reg", regulatorLowPower, 8'h00);
    wake(10'h080);
    lowSpeedOnly = 1'h1;
    enter(SLEEP_IDLE);
    check("slow osc reg", regulatorLowPower, 8'h01);
    wake(10'h001);
    lowSpeedOnly = 1'h0;
    $display("test_idle done");
  endtask

  task automatic test_standby();
    groupRunStandby = 7'h55;
    customClkRunStandby = 1'h1;
    rtcRunStandby = 1'h1;
    enter(SLEEP_STANDBY);
    check("stby group", {1'h0, periphRun}, 8'h55);
    check("stby others", otherPeriphRun, 8'h00);
    check("stby main", mainClkRun, 8'h00);
    check("stby custom clk", customClkRun, 8'h01);
    check("stby timer d", timerDClkRun, 8'h00);
    check("stby rtc", rtcRun, 8'h01);
    check("stby reg", regulatorLowPower, 8'h01);
    check("stby wdt", {wdtOscRun, alwaysOnRun}, 8'h03);
    hold(10'h080);
    check("stby other irq", sleeping, 8'h01);
    hold(10'h200);
    check("stby sync pin", sleeping, 8'h01);
    wake(10'h020);
    $display("test_standby done");
  endtask

  task automatic test_deep_power_down();
    hotLeakageReduceEnable = 1'h1;
    tickEnable = 1'h1;
    brownoutSampledMode = 1'h1;
    mainRunStandby = 1'h1;
    groupRunStandby = 7'h7f;
    enter(SLEEP_POWERDOWN);
    check("pd leak", leakageReduce, 8'h01);
    check("pd main", mainClkRun, 8'h00);
    check("pd group", {1'h0, periphRun}, 8'h00);
    check("pd rtc tick", {rtcRun, tickRun, rtcClkRun}, 8'h03);
    check("pd brownout osc", brownoutOscRun, 8'h01);
    check("pd wdt", wdtOscRun, 8'h01);
    hold(10'h020);
    check("pd sof", sleeping, 8'h01);
    hold(10'h200);
    check("pd sync pin", sleeping, 8'h01);
    wake(10'h100);
    hotLeakageReduceEnable = 1'h0;
    $display("test_deep_power_down done");
  endtask

  task automatic test_lut();
    brownoutSampledMode = 1'h0;
    lutFilterSelect[0] = 2'h1;
    enter(SLEEP_POWERDOWN);
    check("pd brownout off", brownoutOscRun, 8'h00);
    hold(10'h010);
    check("lut filtered", sleeping, 8'h01);
    lutFilterSelect[0] = 2'h0;
    lutEdgeDetect[0] = 1'h1;
    hold(10'h010);
    check("lut edge", sleeping, 8'h01);
    lutEdgeDetect[0] = 1'h0;
    wake(10'h010);
    regulatorPowerSelect = REG_FULL;
    enter(SLEEP_POWERDOWN);
    check("full reg", regulatorLowPower, 8'h00);
    wake(10'h008);
    $display("test_lut done");
  endtask

  // main sequence: reset for 12 cycles, then the scenarios
  initial
  begin
    step(12);
    rstn = 1'h1;
    step(1);
    test_refuse();
    test_idle();
    test_standby();
    test_deep_power_down();
    test_lut();
    finish_test();
  end

  // the run needs some 130 cycles; over fifteen times that means a hang
  initial
  begin
    #(50 * 2000);
    nFail++;
    finish_test();
  end
endmodule
`default_nettype wire
